/* File: logic/fppio_pkg.sv */
// Package of offsets, field layouts and reset values for the parallel I/O block
package fppio_pkg;
    localparam logic [2:0] FPPIO_OFF_A_DATA  = 3'h0;
    localparam logic [2:0] FPPIO_OFF_B_DATA  = 3'h1;
    localparam logic [2:0] FPPIO_OFF_C_DATA  = 3'h2;
    localparam logic [2:0] FPPIO_OFF_D_DATA  = 3'h3;
    localparam logic [2:0] FPPIO_OFF_A_DIR   = 3'h4;
    localparam logic [2:0] FPPIO_OFF_B_DIR   = 3'h5;
    localparam logic [2:0] FPPIO_OFF_C_DIR   = 3'h6;
    localparam logic [2:0] FPPIO_OFF_D_DIR   = 3'h7;
    // Implemented and output-capable bits of the narrow ports
    localparam logic [7:0] FPPIO_B_MASK      = 8'he0;
    localparam logic [7:0] FPPIO_D_MASK      = 8'ha0;
    localparam logic [7:0] FPPIO_D_OUT_MASK  = 8'h20;
    // Fixed read values of unimplemented bits, direction reset and idle read value
    localparam logic [7:0] FPPIO_B_DATA_FILL = 8'h00;
    localparam logic [7:0] FPPIO_D_DATA_FILL = 8'h10;
    localparam logic [7:0] FPPIO_B_DIR_FILL  = 8'h1f;
    localparam logic [7:0] FPPIO_D_DIR_FILL  = 8'h00;
    localparam logic [7:0] FPPIO_DIR_RESET   = 8'h00;
    localparam logic [7:0] FPPIO_READ_IDLE   = 8'h00;
endpackage : fppio_pkg

/* File: logic/fppio_pin_slice.sv */
// One port of pin logic: data latch, direction register, read mux
`timescale 1ns/10ps
`default_nettype none
module fppio_pin_slice
    import fppio_pkg::*;
#(
    parameter logic [7:0] IMPL_MASK = 8'hff,
    parameter logic [7:0] OUT_MASK  = 8'hff,
    parameter logic [7:0] DATA_FILL = 8'h00,
    parameter logic [7:0] DIR_FILL  = 8'h00
) (
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  wire logic       data_we,
    input  wire logic       dir_we,
    input  wire logic [7:0] wdata,
    input  wire logic [7:0] pin_in,
    output logic      [7:0] data_rd,
    output logic      [7:0] dir_rd,
    output logic      [7:0] latch_q,
    output logic      [7:0] dir_q
);
    logic [7:0] latch_r;
    logic [7:0] dir_r;
    wire  [7:0] latch_nxt = (latch_r & ~IMPL_MASK) | (wdata & IMPL_MASK);
    wire  [7:0] dir_nxt   = wdata & OUT_MASK; // R16
    // Latch loads on any write, whatever the direction; no reset
    always_ff @(posedge clock) begin
        if (data_we) begin
            latch_r <= latch_nxt; // R5 R9 R10
        end
    end
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            dir_r <= FPPIO_DIR_RESET; // R6
        end else if (dir_we) begin
            dir_r <= dir_nxt;
        end
    end
    // Output bits read the latch, input bits read the pin
    assign data_rd = (((latch_r & dir_r) | (pin_in & ~dir_r)) & IMPL_MASK)
                     | (DATA_FILL & ~IMPL_MASK); // R11 R12 R13 R16
    assign dir_rd  = (dir_r & OUT_MASK) | (DIR_FILL & ~OUT_MASK); // R8 R16
    assign latch_q = latch_r;
    assign dir_q   = dir_r;
endmodule : fppio_pin_slice
`default_nettype wire

/* File: logic/fppio_top.sv */
// Four-port parallel I/O block on the internal processor bus
// Summary of operation
// R1: Port A eight pins, offsets 0 and 4
// R2: Port B bits five-seven, offsets 1 and 5
// R3: Port C eight pins, offsets 2 and 6
// R4: Port D bit five I/O, bit seven input
// R5: Data latches keep contents through reset
// R6: Reset clears all direction bits to input
// R7: Direction one drives pin, zero floats
// R8: Direction registers readable and writable
// R9: Write with direction zero loads latch only
// R10: Write with direction one loads and drives
// R11: Read of input bit returns pin level
// R12: Read of output bit returns latch
// R13: Input-only bit always readable
// R14: Input-only pin feeds timer capture
// R15: Port A pullup, interrupt set at build
// R16: Unimplemented bits ignore writes, read constant
`timescale 1ns/10ps
`default_nettype none
module fppio_top
    import fppio_pkg::*;
#(
    parameter logic [7:0] PULLUP_EN = 8'h00,
    parameter logic [7:0] KEYIRQ_EN = 8'h00
) (
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  wire logic [2:0] bus_addr,
    input  wire logic       bus_sel,
    input  wire logic       bus_wr,
    input  wire logic [7:0] bus_wdata,
    output logic      [7:0] bus_rdata,
    input  wire logic [7:0] first_port_pins_in,
    output logic      [7:0] first_port_pins_out,
    output logic      [7:0] first_port_pins_oe,
    output logic      [7:0] first_port_pullup,
    output logic      [7:0] first_port_keyirq_en,
    input  wire logic [7:0] second_port_pins_in,
    output logic      [7:0] second_port_pins_out,
    output logic      [7:0] second_port_pins_oe,
    input  wire logic [7:0] third_port_pins_in,
    output logic      [7:0] third_port_pins_out,
    output logic      [7:0] third_port_pins_oe,
    input  wire logic       fourth_port_io_bit_in,
    output logic            fourth_port_io_bit_out,
    output logic            fourth_port_io_bit_oe,
    input  wire logic       fourth_port_input_bit,
    output logic            timer_capture_input
);
    logic [7:0] data_rd [4];
    logic [7:0] dir_rd  [4];
    logic [7:0] latch_q [4];
    logic [7:0] dir_q   [4];
    logic [7:0] pin_v   [4];
    logic [7:0] rdata_r;
    logic [7:0] a_out_r, a_oe_r, b_out_r, b_oe_r, c_out_r, c_oe_r;
    logic       d_out_r, d_oe_r, cap_r;
    logic [7:0] pull_r, kirq_r;

    function automatic logic hit(input logic [2:0] a, input logic [2:0] o);
        return a == o;
    endfunction

    wire wr_cyc = bus_sel & bus_wr;
    wire rd_cyc = bus_sel & ~bus_wr;
    wire [7:0] d_pins = {fourth_port_input_bit, 1'b0,
                         fourth_port_io_bit_in, 5'h00};
    assign pin_v[0] = first_port_pins_in;
    assign pin_v[1] = second_port_pins_in;
    assign pin_v[2] = third_port_pins_in;
    assign pin_v[3] = d_pins;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_port
            localparam logic [7:0] IM = (g == 1) ? FPPIO_B_MASK :
                                        (g == 3) ? FPPIO_D_MASK : 8'hff;
            localparam logic [7:0] OM = (g == 1) ? FPPIO_B_MASK :
                                        (g == 3) ? FPPIO_D_OUT_MASK : 8'hff;
            localparam logic [7:0] DF = (g == 3) ? FPPIO_D_DATA_FILL
                                                 : FPPIO_B_DATA_FILL;
            localparam logic [7:0] RF = (g == 1) ? FPPIO_B_DIR_FILL
                                                 : FPPIO_D_DIR_FILL;
            fppio_pin_slice #(
                .IMPL_MASK (IM),
                .OUT_MASK  (OM),
                .DATA_FILL (DF),
                .DIR_FILL  (RF)
            ) u_slice (
                .clock   (clock),
                .rst_b   (rst_b),
                .data_we (wr_cyc & hit(bus_addr, 3'(g))), // R1 R2 R3 R4
                .dir_we  (wr_cyc & hit(bus_addr, 3'(g + 4))), // R8
                .wdata   (bus_wdata),
                .pin_in  (pin_v[g]),
                .data_rd (data_rd[g]),
                .dir_rd  (dir_rd[g]),
                .latch_q (latch_q[g]),
                .dir_q   (dir_q[g])
            );
        end
    endgenerate

    // Read select: low half data, high half direction
    wire [7:0] rd_sel = bus_addr[2] ? dir_rd[bus_addr[1:0]]
                                    : data_rd[bus_addr[1:0]];
    wire [7:0] rdata_nxt = rd_cyc ? rd_sel : FPPIO_READ_IDLE;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rdata_r <= FPPIO_READ_IDLE;
        end else begin
            rdata_r <= rdata_nxt; // R11 R12
        end
    end

    // Pin drivers registered so every output starts from a flip-flop
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            a_out_r <= 8'h00;
            a_oe_r  <= 8'h00; // R6
            b_out_r <= 8'h00;
            b_oe_r  <= 8'h00;
            c_out_r <= 8'h00;
            c_oe_r  <= 8'h00;
            d_out_r <= 1'b0;
            d_oe_r  <= 1'b0;
            cap_r   <= 1'b0;
            pull_r  <= 8'h00;
            kirq_r  <= 8'h00;
        end else begin
            a_out_r <= latch_q[0];
            a_oe_r  <= dir_q[0]; // R7 R10
            b_out_r <= latch_q[1] & FPPIO_B_MASK;
            b_oe_r  <= dir_q[1] & FPPIO_B_MASK; // R7
            c_out_r <= latch_q[2];
            c_oe_r  <= dir_q[2]; // R7
            d_out_r <= latch_q[3][5];
            d_oe_r  <= dir_q[3][5]; // R7
            cap_r   <= fourth_port_input_bit; // R14
            pull_r  <= PULLUP_EN; // R15
            kirq_r  <= KEYIRQ_EN; // R15
        end
    end

    assign bus_rdata              = rdata_r;
    assign first_port_pins_out    = a_out_r;
    assign first_port_pins_oe     = a_oe_r;
    assign first_port_pullup      = pull_r;
    assign first_port_keyirq_en   = kirq_r;
    assign second_port_pins_out   = b_out_r;
    assign second_port_pins_oe    = b_oe_r;
    assign third_port_pins_out    = c_out_r;
    assign third_port_pins_oe     = c_oe_r;
    assign fourth_port_io_bit_out = d_out_r;
    assign fourth_port_io_bit_oe  = d_oe_r;
    assign timer_capture_input    = cap_r;
endmodule : fppio_top
`default_nettype wire

/* File: tb/fppio_top_asserts.sv */
// Port checks for the parallel I/O block
`timescale 1ns/10ps
`default_nettype none
module fppio_asserts (
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  wire logic [2:0] bus_addr,
    input  wire logic       bus_sel,
    input  wire logic       bus_wr,
    input  wire logic [7:0] bus_wdata,
    input  wire logic [7:0] bus_rdata,
    input  wire logic [7:0] first_port_pins_oe,
    input  wire logic [7:0] second_port_pins_oe,
    input  wire logic [7:0] third_port_pins_oe,
    input  wire logic       fourth_port_input_bit,
    input  wire logic       timer_capture_input
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence s_acc(logic w, logic [2:0] a);
        bus_sel && bus_wr == w && bus_addr == a;
    endsequence
    AST_A_OE: assert property (s_acc(1'b1, 3'h4) |-> ##2
        first_port_pins_oe == $past(bus_wdata, 2)) else $error("a_oe");
    AST_C_OE: assert property (s_acc(1'b1, 3'h6) |-> ##2
        third_port_pins_oe == $past(bus_wdata, 2)) else $error("c_oe");
    AST_B_FIXED: assert property (second_port_pins_oe[4:0] == 5'h00)
        else $error("b_oe");
    AST_RST_DIR: assert property ($rose(rst_b) |-> ##1
        (first_port_pins_oe | third_port_pins_oe) == 8'h00)
        else $error("rst");
    AST_CAPTURE: assert property ($past(rst_b) |->
        timer_capture_input == $past(fourth_port_input_bit))
        else $error("cap");
    AST_D_READ: assert property (s_acc(1'b0, 3'h3) |=>
        bus_rdata[7] == $past(fourth_port_input_bit)
        && (bus_rdata & 8'h5f) == 8'h10) else $error("d_rd");
    AST_B_DIR: assert property (s_acc(1'b0, 3'h5) |=>
        bus_rdata[4:0] == 5'h1f) else $error("b_dir");
    AST_D_DIR: assert property (s_acc(1'b0, 3'h7) |=>
        (bus_rdata & 8'hdf) == 8'h00) else $error("d_dir");
endmodule : fppio_asserts
`default_nettype wire

/* File: tb/fppio_pins_model.sv */
// Pin loads: a driven pin follows the block, an idle one the load
`timescale 1ns/10ps
`default_nettype none
module fppio_pins_model (
    input  wire logic [24:0] drv,
    input  wire logic [24:0] oe,
    input  wire logic [24:0] ext,
    output logic      [24:0] lvl
);
    assign lvl = (drv & oe) | (ext & ~oe);
endmodule : fppio_pins_model
`default_nettype wire

/* File: tb/test_fppio_top.sv */
// Self-checking bench for the parallel I/O block
`timescale 1ns/10ps
`default_nettype none
module test_fppio_top
    import fppio_pkg::*;
;
    logic        clock = 1'b0, rst_b = 1'b0, sel = 1'b0, din = 1'b1;
    logic        dov, doe, tc;
    logic [7:0]  pu, ki;
    logic [11:0] req = 12'h000;
    logic [8:0]  ex = 9'h000;
    logic [7:0]  rd, ao, ae, bo, be, co, ce;
    logic [24:0] lvl, ext = {8'h5a, 8'h5f, 8'h3c, 1'b0};
    int          fail_count = 0, compares = 0;
    logic [11:0] rows [23] = '{12'hcf0, 12'h8a5, 12'h4f0, 12'h0aa, 12'h140,
        12'hdff, 12'h5ff, 12'h9a0, 12'h1a0, 12'he0f, 12'hac3, 12'h233,
        12'h60f, 12'hfff, 12'h720, 12'hbff, 12'h3b0, 12'h23c, 12'heff,
        12'h2c3, 12'hcff, 12'h0a5, 12'h310};
    always #5 clock = ~clock;
    fppio_top fppio_top_inst (.clock(clock), .rst_b(rst_b), .bus_sel(sel),
        .bus_addr(req[10:8]), .bus_wr(req[11]), .bus_wdata(req[7:0]),
        .bus_rdata(rd), .first_port_pins_in(lvl[24:17]),
        .first_port_pins_out(ao), .first_port_pins_oe(ae),
        .first_port_pullup(pu), .first_port_keyirq_en(ki),
        .second_port_pins_in(lvl[16:9]), .second_port_pins_out(bo),
        .second_port_pins_oe(be), .third_port_pins_in(lvl[8:1]),
        .third_port_pins_out(co), .third_port_pins_oe(ce),
        .fourth_port_io_bit_in(lvl[0]), .fourth_port_io_bit_out(dov),
        .fourth_port_io_bit_oe(doe), .fourth_port_input_bit(din),
        .timer_capture_input(tc));
    fppio_pins_model fppio_pins_model_inst (.drv({ao, bo, co, dov}),
        .oe({ae, be, ce, doe}), .ext(ext), .lvl(lvl));
    task chk(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task op(input logic s, input logic [11:0] r);
        @(negedge clock);
        chk(rd, ex[8] ? ex[7:0] : FPPIO_READ_IDLE);
        sel = s;
        req = r;
        ex = {s & ~r[11], r[7:0]};
    endtask : op
    task wrap_up();
        $display("%0d compares, %0d fails", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (16) @(negedge clock);
        rst_b = 1'b1;
        for (int i = 0; i < 23; i++) begin
            if (i == 17) begin
                op(1'b0, 12'h000);
                $display("table done");
                chk(ae & ao, 8'ha0);
                chk(ce | be, 8'hef);
                chk(pu | ki, 8'h00);
                chk({7'h00, tc}, 8'h01);
                rst_b = 1'b0;
                din = 1'b0;
                @(negedge clock);
                chk(ae | be | ce | {7'h00, doe}, 8'h00);
                rst_b = 1'b1;
            end
            op(1'b1, rows[i]);
        end
        op(1'b0, 12'h000);
        $display("reset case done");
        wrap_up();
    end
endmodule : test_fppio_top
bind fppio_top fppio_asserts fppio_asserts_inst (.*);
`default_nettype wire
